//--- logic/iss_spi_port.sv
// Serial slave port with sync-driven data-invalid window
`timescale 1ns/100ps
`include "iss_consts.svh"
module iss_spi_port
  import iss_pkg::*;
#(
  parameter int SYNC_INVALID_CYC = `ISS_SYNC_INVALID_CYC
)
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic din_in,
  output logic dout_out,
  output logic dout_oe_out,
  input wire logic sync_in,
  input wire logic [15:0] rd_data_in,
  output logic wr_valid_out,
  output logic [6:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  output logic rd_req_out,
  output logic [6:0] rd_addr_out,
  output logic data_invalid_out
);
  logic [2:0] sclk_q, sclk_d;
  logic [2:0] cs_q, cs_d;
  logic [1:0] din_q, din_d;
  logic [2:0] sync_q, sync_d;
  iss_state_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] rx_q, rx_d;
  logic [15:0] tx_q, tx_d;
  logic [15:0] rdbuf_q, rdbuf_d;
  logic dout_q, dout_d;
  logic wr_q, wr_d;
  logic rd_q, rd_d;
  logic [6:0] wa_q, wa_d, ra_q, ra_d;
  logic [7:0] wd_q, wd_d;
  logic [31:0] inv_q, inv_d;
  logic inv_flag_q, inv_flag_d;
  logic rise, fall, sel;

  // Target address field of a received frame
  function automatic logic [6:0] frame_addr(input logic [15:0] frame);
    frame_addr = frame[`ISS_ADDR_HI:`ISS_ADDR_LO];
  endfunction : frame_addr

  // Synchronizer taps; only the second and third stages are read
  assign rise = sclk_q[1] & ~sclk_q[2];
  assign fall = ~sclk_q[1] & sclk_q[2];
  assign sel = ~cs_q[1];

  // Next state for synchronizers, shifter and outputs
  always_comb
  begin
    sclk_d = {sclk_q[1:0], sclk_in};
    cs_d = {cs_q[1:0], cs_n_in};
    din_d = {din_q[0], din_in};
    sync_d = {sync_q[1:0], sync_in};
    st_d = st_q;
    cnt_d = cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    rdbuf_d = rdbuf_q;
    dout_d = dout_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    wa_d = wa_q;
    wd_d = wd_q;
    ra_d = ra_q;
    unique case (st_q)
      ISS_IDLE:
      begin
        if (sel)
        begin
          st_d = ISS_SHIFT;
          cnt_d = 5'h00;
          tx_d = rdbuf_q;
          dout_d = rdbuf_q[15];
        end
      end
      ISS_SHIFT:
      begin
        if (!sel)
          st_d = ISS_IDLE;
        else
        begin
          if (rise)
          begin
            rx_d = {rx_q[14:0], din_q[1]};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'(`ISS_WORD_BITS - 1))
              st_d = ISS_DONE;
          end
          if (fall && cnt_q != 5'h00)
          begin
            tx_d = {tx_q[14:0], 1'b0};
            dout_d = tx_q[14];
          end
        end
      end
      ISS_DONE:
      begin
        // Word complete; act once select is released
        if (!sel)
        begin
          st_d = ISS_IDLE;
          if (rx_q[`ISS_WR_BIT])
          begin
            wr_d = 1'b1;
            wa_d = frame_addr(rx_q);
            wd_d = rx_q[7:0];
          end
          else
          begin
            rd_d = 1'b1;
            ra_d = frame_addr(rx_q);
          end
        end
      end
      default:
        st_d = ISS_IDLE;
    endcase
    // Latch register contents one cycle after a read request
    if (rd_q)
      rdbuf_d = rd_data_in;
  end

  // Data-invalid window after a sync rising edge
  always_comb
  begin
    inv_d = inv_q;
    inv_flag_d = inv_flag_q;
    if (sync_q[1] & ~sync_q[2])
    begin
      // Counter width covers the full window at the system clock rate
      inv_d = 32'(SYNC_INVALID_CYC);
      inv_flag_d = 1'b0;
    end
    else if (inv_q != 32'h0)
    begin
      inv_d = inv_q - 32'h1;
      if (inv_q == 32'h1)
        inv_flag_d = 1'b1;
    end
    else if (!sync_q[1])
      inv_flag_d = 1'b0;
  end

  // Registers
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      sclk_q <= 3'h7;
      cs_q <= 3'h7;
      din_q <= 2'h0;
      sync_q <= 3'h0;
      st_q <= ISS_IDLE;
      cnt_q <= 5'h00;
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      rdbuf_q <= 16'h0000;
      dout_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      wa_q <= 7'h00;
      wd_q <= 8'h00;
      ra_q <= 7'h00;
      inv_q <= 32'h0;
      inv_flag_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_d;
      cs_q <= cs_d;
      din_q <= din_d;
      sync_q <= sync_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      rdbuf_q <= rdbuf_d;
      dout_q <= dout_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      ra_q <= ra_d;
      inv_q <= inv_d;
      inv_flag_q <= inv_flag_d;
    end
  end

  // Outputs
  assign dout_out = dout_q;
  assign dout_oe_out = sel;
  assign wr_valid_out = wr_q;
  assign wr_addr_out = wa_q;
  assign wr_data_out = wd_q;
  assign rd_req_out = rd_q;
  assign rd_addr_out = ra_q;
  assign data_invalid_out = inv_flag_q;
endmodule : iss_spi_port

//--- logic/iss_consts.svh
// Constants for the inertial sensor serial slave port
`ifndef ISS_CONSTS_SVH
`define ISS_CONSTS_SVH
`define ISS_CLK_MHZ 250
`define ISS_WORD_BITS 16
`define ISS_SYNC_INVALID_US 490
`define ISS_SYNC_INVALID_CYC (`ISS_SYNC_INVALID_US * `ISS_CLK_MHZ)
`define ISS_WR_BIT 15
`define ISS_ADDR_HI 14
`define ISS_ADDR_LO 8
`endif

//--- logic/iss_pkg.sv
// Types for the inertial sensor serial slave port
package iss_pkg;
  typedef enum logic [1:0] {ISS_IDLE, ISS_SHIFT, ISS_DONE} iss_state_t;
endpackage : iss_pkg

//--- test/iss_spi_port_asserts.sv
// Port checks for the serial slave port
`timescale 1ns/100ps
module iss_asserts #(parameter int SYNC_INVALID_CYC = 50)
(
  input logic clk_in,
  input logic sys_rst_in,
  input logic sclk_in,
  input logic cs_n_in,
  input logic sync_in,
  input logic dout_out,
  input logic dout_oe_out,
  input logic wr_valid_out,
  input logic rd_req_out,
  input logic data_invalid_out
);
  localparam int INV_HI = SYNC_INVALID_CYC + 8;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Output timing and decoded requests
  property p_hold; $rose(sclk_in) |=> $stable(dout_out)[*8]; endproperty
  a_hold: assert property (p_hold) else $error("dout moved");
  property p_off; cs_n_in[*4] |-> !dout_oe_out; endproperty
  a_off: assert property (p_off) else $error("dout driven");
  property p_on; (!cs_n_in)[*4] |-> dout_oe_out; endproperty
  a_on: assert property (p_on) else $error("dout idle");
  property p_inv; $rose(sync_in) |-> ##[SYNC_INVALID_CYC:INV_HI] data_invalid_out; endproperty
  a_inv: assert property (p_inv) else $error("no invalid");
  property p_wr; wr_valid_out |-> cs_n_in && $past(cs_n_in, 2) && !rd_req_out; endproperty
  a_wr: assert property (p_wr) else $error("early write");
  property p_wp; wr_valid_out |=> !wr_valid_out; endproperty
  a_wp: assert property (p_wp) else $error("long write");
  property p_rd; rd_req_out |=> !rd_req_out && !wr_valid_out; endproperty
  a_rd: assert property (p_rd) else $error("long read");
  cover property (wr_valid_out);
  cover property (rd_req_out);
  cover property (data_invalid_out);
endmodule : iss_asserts
bind iss_spi_port iss_asserts #(.SYNC_INVALID_CYC(SYNC_INVALID_CYC)) u_chk (
  .clk_in(clk_in),
  .sys_rst_in(sys_rst_in),
  .sclk_in(sclk_in),
  .cs_n_in(cs_n_in),
  .sync_in(sync_in),
  .dout_out(dout_out),
  .dout_oe_out(dout_oe_out),
  .wr_valid_out(wr_valid_out),
  .rd_req_out(rd_req_out),
  .data_invalid_out(data_invalid_out)
);

//--- test/iss_master.sv
// Serial master for mode 3 frames
`timescale 1ns/100ps
module iss_master
(
  output logic sclk_out = 1'b1,
  output logic cs_n_out = 1'b1,
  output logic din_out = 1'b0,
  input logic dout_in
);
  // One word each way, then the stall gap in microseconds
  task xfer(input logic [15:0] w, input int gap_us, output logic [15:0] r);
    cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      #62.5 sclk_out = 0;
      din_out = w[i];
      #62.5 sclk_out = 1;
      r[i] = dout_in;
    end
    #62.5 cs_n_out = 1'b1;
    din_out = !din_out;
    // Caller passes any longer register-specific stall; select stays high
    repeat ((gap_us > 2) ? gap_us : 2) #1000;
  endtask : xfer
endmodule : iss_master

//--- test/iss_spi_port_tb.sv
// Bench for the serial slave port
`timescale 1ns/100ps
module iss_spi_port_tb;
  logic clk_in = 0, sys_rst_in = 1, sync_in = 0;
  logic [15:0] r;
  wire [15:0] rd_data_in;
  wire sclk_in, cs_n_in, din_in, dout_out, dout_oe_out, wr_valid_out, rd_req_out, data_invalid_out;
  wire [6:0] wr_addr_out, rd_addr_out;
  wire [7:0] wr_data_out;
  int mismatches = 0, n_checks = 0;
  initial forever #2 clk_in = ~clk_in;
  // Register file model: contents carry their own address
  assign rd_data_in = {1'b1, rd_addr_out, 8'ha5};
  iss_spi_port #(.SYNC_INVALID_CYC(50)) DUT (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .din_in(din_in),
    .dout_out(dout_out),
    .dout_oe_out(dout_oe_out),
    .sync_in(sync_in),
    .rd_data_in(rd_data_in),
    .wr_valid_out(wr_valid_out),
    .wr_addr_out(wr_addr_out),
    .wr_data_out(wr_data_out),
    .rd_req_out(rd_req_out),
    .rd_addr_out(rd_addr_out),
    .data_invalid_out(data_invalid_out)
  );
  // Released data line shows the inverse of the last driven bit
  iss_master M (
    .sclk_out(sclk_in),
    .cs_n_out(cs_n_in),
    .din_out(din_in),
    .dout_in(dout_oe_out ? dout_out : ~dout_out)
  );
  task chk(string s, logic [15:0] e, v);
    @(negedge clk_in);
    n_checks++;
    mismatches += int'(v !== e);
    if (v !== e) $display("[ERR] %s exp %h got %h", s, e, v);
  endtask : chk
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task tick(int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  // Write, three reads, then sync window
  initial
  begin
    tick(4);
    sys_rst_in <= 0;
    tick(8);
    M.xfer(16'ha35c, 2, r);
    chk("wr", 16'h235c, {1'b0, wr_addr_out, wr_data_out});
    M.xfer(16'h1a00, 2, r);
    M.xfer(16'h1800, 2, r);
    chk("rd", 16'h9aa5, r);
    chk("ra", 16'h0018, {9'h000, rd_addr_out});
    M.xfer(16'h0000, 2, r);
    chk("rd2", 16'h98a5, r);
    tick(1);
    sync_in <= 1;
    tick(40);
    chk("early", 16'h0, {15'h0, data_invalid_out});
    tick(1260);
    chk("inval", 16'h1, {15'h0, data_invalid_out});
    $display("link and sync test done");
    stop_test;
  end
endmodule : iss_spi_port_tb
